// ---- hw/hci_host_control_interface.sv ----
// Behaviour
// - low edge select updates output on rise
// - high edge select updates output on fall
// - strobe mode captures writes, drives reads
// - split mode drives bus while read low
// - serial input sampled on shift rising edge
// - write strobe rise lands write; data sampled while low
// - hardware loop pins pick channel 2 loopback
// - inband loopback only under software control
// - hardware line pins set channel 1 mode
// - channel 1 line pins set common mode
// - accesses honoured only while select low
`timescale 1ns/1ps
`default_nettype none
module hci_host_control_interface (
    input  wire logic                          ref_clk,
    input  wire logic                          rst_n,
    // apb slave
    input  wire logic [hci_pkg::APB_AW-1:0]    paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // serial microcontroller port
    input  wire logic                          shiftClk,
    input  wire logic                          csN,
    input  wire logic                          serialIn,
    input  wire logic                          serialOutEdgeSel,
    output logic                               serialOut,
    // parallel microcontroller port
    input  wire logic [hci_pkg::ADDR_W-1:0]    addrBus,
    input  wire logic [hci_pkg::DATA_W-1:0]    dataIn,
    output logic      [hci_pkg::DATA_W-1:0]    dataOut,
    output logic                               dataOeN,
    input  wire logic                          dataStrobeN,
    input  wire logic                          rdWrSel,
    input  wire logic                          readStrobeN,
    input  wire logic                          writeStrobeN,
    // hardware control pins
    input  wire hci_pkg::hci_hw_pins_s         hwPins,
    // towards the register file and line side
    output hci_pkg::hci_host_wr_s              hostWr,
    output logic      [hci_pkg::LINE_W-1:0]    ch1LineMode,
    output logic      [hci_pkg::LINE_W-1:0]    commonLineMode,
    output logic      [hci_pkg::LOOP_W-1:0]    ch2LoopMode
);
    import hci_pkg::*;

    localparam int CTL_W  = 5;
    localparam int PIN_W  = CTL_W + DATA_W + ADDR_W + LINE_W + 2;
    localparam int WORD_W = ADDR_W + DATA_W;

    // ==========================================================
    // declarations
    logic [PIN_W-1:0]       pinSync1_reg;
    logic [PIN_W-1:0]       pinSync2_reg;
    logic [PIN_W-1:0]       pinPrev_reg;
    logic [PIN_W-1:0]       pinRaw;

    logic                   cs2;
    logic                   ds2;
    logic                   rw2;
    logic                   rd2;
    logic                   wr2;
    logic [DATA_W-1:0]      data2;
    logic [ADDR_W-1:0]      addr2;
    logic [LINE_W-1:0]      line2;
    logic                   loopHi2;
    logic                   loopLo2;

    logic                   csPrev;
    logic                   dsPrev;
    logic                   rwPrev;
    logic                   wrPrev;
    logic [DATA_W-1:0]      dataPrev;
    logic [ADDR_W-1:0]      addrPrev;

    logic [CTRL_W-1:0]      ctrl_reg;
    logic [DATA_W-1:0]      rdData_reg;
    logic [DATA_W-1:0]      rdShadow_reg;
    logic [7:0]             wrCount_reg;
    logic                   apbReady_reg;
    logic [31:0]            prdata_reg;
    logic                   pslverr_reg;
    logic                   dataOeN_reg;
    logic [DATA_W-1:0]      dataOut_reg;
    hci_host_wr_s           hostWr_reg;
    hci_host_wr_s           hostWr_next;
    logic [LINE_W-1:0]      line_reg;
    logic [LOOP_W-1:0]      loop_reg;

    logic [MODE_W-1:0]      mode;
    logic                   hwCtrl;
    logic [LOOP_W-1:0]      swLoop;
    logic [LINE_W-1:0]      swLine;
    logic                   modeStrobe;
    logic                   modeSplit;
    logic                   modeSerial;

    logic                   readDrive;
    logic                   strobeWrite;
    logic                   splitWrite;
    logic                   parWrite;
    logic                   serialWrite;

    logic [WORD_W-1:0]      serWord;
    logic                   serToggle;
    logic                   togSync1_reg;
    logic                   togSync2_reg;
    logic                   togPrev_reg;

    logic [LOOP_W-1:0]      loop_next;
    logic [LINE_W-1:0]      line_next;

    logic                   apbSetup;
    logic                   apbDo;
    logic                   selCtrl;
    logic                   selRdData;
    logic                   selStatus;
    logic                   selLastWr;
    logic                   apbHit;
    logic [31:0]            rdMux;
    logic [31:0]            statusWord;
    logic [31:0]            lastWrWord;

    // ==========================================================
    // pin synchronisers; stage 1 feeds only stage 2
    assign pinRaw = {csN, dataStrobeN, rdWrSel, readStrobeN, writeStrobeN,
                     dataIn, addrBus, hwPins.ch1LineSelect,
                     hwPins.ch2LoopSelHi, hwPins.ch2LoopSelLo};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinSync1_reg <= '1;
            pinSync2_reg <= '1;
            pinPrev_reg  <= '1;
        end else begin
            pinSync1_reg <= pinRaw;
            pinSync2_reg <= pinSync1_reg;
            pinPrev_reg  <= pinSync2_reg;
        end
    end

    assign {cs2, ds2, rw2, rd2, wr2, data2, addr2, line2, loopHi2, loopLo2} = pinSync2_reg;
    assign csPrev   = pinPrev_reg[PIN_W-1];
    assign dsPrev   = pinPrev_reg[PIN_W-2];
    assign rwPrev   = pinPrev_reg[PIN_W-3];
    assign wrPrev   = pinPrev_reg[PIN_W-5];
    assign dataPrev = pinPrev_reg[PIN_W-CTL_W-1 -: DATA_W];
    assign addrPrev = pinPrev_reg[PIN_W-CTL_W-DATA_W-1 -: ADDR_W];

    // ==========================================================
    // control fields
    assign mode       = ctrl_reg[CTRL_MODE_LSB +: MODE_W];
    assign hwCtrl     = ctrl_reg[CTRL_HW_BIT];
    assign swLoop     = ctrl_reg[CTRL_LOOP_LSB +: LOOP_W];
    assign swLine     = ctrl_reg[CTRL_LINE_LSB +: LINE_W];
    assign modeStrobe = (mode == MODE_STROBE);
    assign modeSplit  = (mode == MODE_SPLIT);
    assign modeSerial = (mode == MODE_SERIAL);

    // ==========================================================
    // parallel port
    // the bus is driven only inside a qualified read window
    assign readDrive = (modeStrobe & ~cs2 & ~ds2 & rw2)
                     | (modeSplit  & ~cs2 & ~rd2);

    // writes land at the strobe's trailing edge, using the last
    // sampled data while the strobe was still low
    assign strobeWrite = modeStrobe & ds2 & ~dsPrev & ~csPrev & ~rwPrev;
    assign splitWrite  = modeSplit  & wr2 & ~wrPrev & ~csPrev;
    assign parWrite    = strobeWrite | splitWrite;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataOeN_reg <= 1'b1;
            dataOut_reg <= 8'h00;
        end else begin
            dataOeN_reg <= ~readDrive;
            dataOut_reg <= rdData_reg;
        end
    end

    assign dataOut = dataOut_reg;
    assign dataOeN = dataOeN_reg;

    // ==========================================================
    // serial port on the shift clock
    // shadow only moves while select is idle, so the shift domain
    // never loads a word that is changing
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdShadow_reg <= 8'h00;
        end else if (cs2) begin
            rdShadow_reg <= rdData_reg;
        end
    end

    hci_serial_engine u_serial (
        .shiftClk         (shiftClk),
        .rst_n            (rst_n),
        .csN              (csN),
        .serialIn         (serialIn),
        .serialOutEdgeSel (serialOutEdgeSel),
        .rdShadow         (rdShadow_reg),
        .serialOut        (serialOut),
        .wrWord           (serWord),
        .wrToggle         (serToggle)
    );

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            togSync1_reg <= 1'b0;
            togSync2_reg <= 1'b0;
            togPrev_reg  <= 1'b0;
        end else begin
            togSync1_reg <= serToggle;
            togSync2_reg <= togSync1_reg;
            togPrev_reg  <= togSync2_reg;
        end
    end

    // the word has been stable for two ref clocks when the toggle lands
    assign serialWrite = modeSerial & (togSync2_reg ^ togPrev_reg);

    // ==========================================================
    // write request towards the register file
    always_comb begin
        hostWr_next       = hostWr_reg;
        hostWr_next.valid = 1'b0;
        if (serialWrite) begin
            hostWr_next.valid = 1'b1;
            hostWr_next.addr  = serWord[WORD_W-1 -: ADDR_W];
            hostWr_next.data  = serWord[DATA_W-1:0];
        end else if (parWrite) begin
            hostWr_next.valid = 1'b1;
            hostWr_next.addr  = addrPrev;
            hostWr_next.data  = dataPrev;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hostWr_reg  <= '0;
            wrCount_reg <= 8'h00;
        end else begin
            hostWr_reg <= hostWr_next;
            if (hostWr_next.valid) begin
                wrCount_reg <= wrCount_reg + 8'h01;
            end
        end
    end

    assign hostWr = hostWr_reg;

    // ==========================================================
    // hardware control decode
    // pins give only 2 bits, so inband cannot be reached by strap
    assign loop_next = hwCtrl ? {1'b0, loopHi2, loopLo2}
                              : ((swLoop > LOOP_INBAND) ? LOOP_NONE : swLoop);
    assign line_next = hwCtrl ? line2 : swLine;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            loop_reg <= 3'h0;
            line_reg <= 4'h0;
        end else begin
            loop_reg <= loop_next;
            line_reg <= line_next;
        end
    end

    assign ch2LoopMode    = loop_reg;
    assign ch1LineMode    = line_reg;
    assign commonLineMode = line_reg;

    // ==========================================================
    // apb slave: one wait state, data from flops
    assign apbSetup  = psel & penable & ~apbReady_reg;
    assign apbDo     = psel & penable & apbReady_reg;
    assign selCtrl   = (paddr == OFS_CTRL);
    assign selRdData = (paddr == OFS_RDDATA);
    assign selStatus = (paddr == OFS_STATUS);
    assign selLastWr = (paddr == OFS_LASTWR);
    assign apbHit    = selCtrl | selRdData | selStatus | selLastWr;

    assign statusWord = {24'h00_0000, cs2, line_reg, loop_reg};
    assign lastWrWord = {8'h00, wrCount_reg, 1'b0, hostWr_reg.addr, hostWr_reg.data};

    assign rdMux = selCtrl   ? {22'h00_0000, ctrl_reg} :
                   selRdData ? {24'h00_0000, rdData_reg} :
                   selStatus ? statusWord :
                   selLastWr ? lastWrWord : 32'h0000_0000;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            apbReady_reg <= 1'b0;
            prdata_reg   <= 32'h0000_0000;
            pslverr_reg  <= 1'b0;
        end else begin
            apbReady_reg <= apbSetup;
            if (apbSetup) begin
                prdata_reg  <= pwrite ? 32'h0000_0000 : rdMux;
                pslverr_reg <= ~apbHit;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg   <= CTRL_RESET;
            rdData_reg <= RDDATA_RESET;
        end else if (apbDo && pwrite) begin
            if (selCtrl) begin
                ctrl_reg <= pwdata[CTRL_W-1:0];
            end
            if (selRdData) begin
                rdData_reg <= pwdata[DATA_W-1:0];
            end
        end
    end

    assign pready  = apbReady_reg;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg & apbReady_reg;

endmodule : hci_host_control_interface
`default_nettype wire

// ---- hw/hci_pkg.sv ----
package hci_pkg;

    // ==========================================================
    // widths
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int APB_AW = 12;
    localparam int LINE_W = 4;
    localparam int LOOP_W = 3;
    localparam int MODE_W = 2;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [APB_AW-1:0] OFS_CTRL   = 12'h000;
    localparam logic [APB_AW-1:0] OFS_RDDATA = 12'h004;
    localparam logic [APB_AW-1:0] OFS_STATUS = 12'h008;
    localparam logic [APB_AW-1:0] OFS_LASTWR = 12'h00c;

    // ==========================================================
    // control register fields and reset values
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_HW_BIT   = 2;
    localparam int CTRL_LOOP_LSB = 3;
    localparam int CTRL_LINE_LSB = 6;
    localparam int CTRL_W        = 10;
    localparam logic [CTRL_W-1:0] CTRL_RESET   = 10'h000;
    localparam logic [DATA_W-1:0] RDDATA_RESET = 8'h00;

    // ==========================================================
    // status and last-write register fields
    localparam int STAT_LOOP_LSB = 0;
    localparam int STAT_LINE_LSB = 3;
    localparam int STAT_IDLE_BIT = 7;
    localparam int LASTWR_ADDR_LSB = 8;
    localparam int LASTWR_CNT_LSB  = 16;

    // ==========================================================
    // microcontroller interface styles
    localparam logic [MODE_W-1:0] MODE_SERIAL = 2'h0;
    localparam logic [MODE_W-1:0] MODE_STROBE = 2'h1;
    localparam logic [MODE_W-1:0] MODE_SPLIT  = 2'h2;

    // ==========================================================
    // loopback codes
    localparam logic [LOOP_W-1:0] LOOP_NONE    = 3'h0;
    localparam logic [LOOP_W-1:0] LOOP_ANALOG  = 3'h1;
    localparam logic [LOOP_W-1:0] LOOP_DIGITAL = 3'h2;
    localparam logic [LOOP_W-1:0] LOOP_REMOTE  = 3'h3;
    localparam logic [LOOP_W-1:0] LOOP_INBAND  = 3'h4;

    // ==========================================================
    // serial frame: rw bit, 7 address bits, 8 data bits
    localparam logic [4:0] SER_CMD_LAST   = 5'h07;
    localparam logic [4:0] SER_FRAME_LAST = 5'h0f;
    localparam logic [4:0] SER_DONE       = 5'h10;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } hci_host_wr_s;

    typedef struct packed {
        logic              ch2LoopSelHi;
        logic              ch2LoopSelLo;
        logic [LINE_W-1:0] ch1LineSelect;
    } hci_hw_pins_s;

endpackage : hci_pkg

// ---- hw/hci_serial_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
module hci_serial_engine (
    input  wire logic                          shiftClk,
    input  wire logic                          rst_n,
    input  wire logic                          csN,
    input  wire logic                          serialIn,
    input  wire logic                          serialOutEdgeSel,
    input  wire logic [hci_pkg::DATA_W-1:0]    rdShadow,
    output logic                               serialOut,
    output logic [hci_pkg::ADDR_W+hci_pkg::DATA_W-1:0] wrWord,
    output logic                               wrToggle
);
    import hci_pkg::*;

    logic                       frameRstN;
    logic [4:0]                 bitCnt_reg;
    logic [14:0]                rxSh_reg;
    logic [DATA_W-1:0]          txSh_reg;
    logic                       outFall_reg;
    logic                       isRead;
    logic                       cmdDone;
    logic                       frameEnd;

    // ==========================================================
    // frame decode
    // chip select high clears the frame; sclk may stop between frames
    assign frameRstN = rst_n & ~csN;
    assign isRead    = rxSh_reg[6];
    assign cmdDone   = (bitCnt_reg == SER_CMD_LAST);
    assign frameEnd  = (bitCnt_reg == SER_FRAME_LAST);

    always_ff @(posedge shiftClk or negedge frameRstN) begin
        if (!frameRstN) begin
            bitCnt_reg <= 5'h00;
            rxSh_reg   <= 15'h0000;
            txSh_reg   <= 8'h00;
        end else begin
            rxSh_reg <= {rxSh_reg[13:0], serialIn};
            if (bitCnt_reg != SER_DONE) begin
                bitCnt_reg <= bitCnt_reg + 5'h01;
            end
            if (cmdDone && isRead) begin
                txSh_reg <= rdShadow;
            end else begin
                txSh_reg <= {txSh_reg[DATA_W-2:0], 1'b0};
            end
        end
    end

    // half-cycle later copy for falling-edge update
    always_ff @(negedge shiftClk or negedge frameRstN) begin
        if (!frameRstN) begin
            outFall_reg <= 1'b0;
        end else begin
            outFall_reg <= txSh_reg[DATA_W-1];
        end
    end

    // edge select is a strap; it must not change during a frame
    assign serialOut = serialOutEdgeSel ? outFall_reg : txSh_reg[DATA_W-1];

    // ==========================================================
    // write word handed over by toggle; word stays until next write
    always_ff @(posedge shiftClk or negedge rst_n) begin
        if (!rst_n) begin
            wrWord   <= 15'h0000;
            wrToggle <= 1'b0;
        end else if (frameEnd && !csN && !rxSh_reg[14]) begin
            wrWord   <= {rxSh_reg[13:0], serialIn};
            wrToggle <= ~wrToggle;
        end
    end

endmodule : hci_serial_engine
`default_nettype wire

// ---- sim/hci_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module hci_properties (
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       shiftClk,
    input wire logic                       csN,
    input wire logic                       serialOutEdgeSel,
    input wire logic                       serialOut,
    input wire logic                       dataOeN,
    input wire logic                       dataStrobeN,
    input wire logic                       rdWrSel,
    input wire logic                       readStrobeN,
    input wire hci_pkg::hci_host_wr_s      hostWr,
    input wire logic [hci_pkg::LINE_W-1:0] ch1LineMode,
    input wire logic [hci_pkg::LINE_W-1:0] commonLineMode
);
    import hci_pkg::*;
    // ==========
    // helpers
    logic       readQual;
    logic       fallSnap;
    logic       riseSnap;
    logic [3:0] csHighCnt;
    assign readQual = !csN && ((!dataStrobeN && rdWrSel) || !readStrobeN);
    // each snapshot holds the value seen just before the other edge
    always_ff @(negedge shiftClk or posedge csN) begin
        if (csN) fallSnap <= 1'b0;
        else fallSnap <= serialOut;
    end
    always_ff @(posedge shiftClk or posedge csN) begin
        if (csN) riseSnap <= 1'b0;
        else riseSnap <= serialOut;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) csHighCnt <= 4'h0;
        else if (!csN) csHighCnt <= 4'h0;
        else if (csHighCnt != 4'hf) csHighCnt <= csHighCnt + 4'h1;
    end
    // ==========
    // properties
    chk_apb_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
        psel && !penable |=> !pready ##1 pready) else $error("apb answer timing wrong");
    chk_ready_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pready |=> !pready) else $error("pready longer than one cycle");
    chk_err_ready: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pslverr |-> pready) else $error("pslverr without pready");
    chk_bus_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !readQual [*4] |-> dataOeN) else $error("bus driven with no read");
    chk_idle_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
        csN |-> !serialOut) else $error("serial output active while deselected");
    chk_sel_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hostWr.valid |-> csHighCnt < 4'h8) else $error("write without chip select");
    chk_write_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hostWr.valid |=> !hostWr.valid) else $error("write pulse too long");
    chk_common_line: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ch1LineMode == commonLineMode) else $error("common line mode differs");
    chk_rise_update: assert property (@(posedge shiftClk) disable iff (!rst_n || csN)
        !serialOutEdgeSel |-> serialOut == fallSnap) else $error("output moved on fall");
    chk_fall_update: assert property (@(negedge shiftClk) disable iff (!rst_n || csN)
        serialOutEdgeSel |-> serialOut == riseSnap) else $error("output moved on rise");
endmodule : hci_properties

bind hci_host_control_interface hci_properties u_props (.ref_clk, .rst_n, .psel, .penable,
    .pready, .pslverr, .shiftClk, .csN, .serialOutEdgeSel, .serialOut, .dataOeN,
    .dataStrobeN, .rdWrSel, .readStrobeN, .hostWr, .ch1LineMode, .commonLineMode);
`default_nettype wire

// ---- sim/hci_micro_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module hci_micro_model (
    input  wire logic                       ref_clk,
    input  wire logic                       serialOutEdgeSel,
    input  wire logic                       serialOut,
    input  wire logic [hci_pkg::DATA_W-1:0] dataOut,
    input  wire logic                       dataOeN,
    output logic                            shiftClk,
    output logic                            csN,
    output logic                            serialIn,
    output logic [hci_pkg::ADDR_W-1:0]      addrBus,
    output logic [hci_pkg::DATA_W-1:0]      dataIn,
    output logic                            dataStrobeN,
    output logic                            rdWrSel,
    output logic                            readStrobeN,
    output logic                            writeStrobeN
);
    import hci_pkg::*;
    // ==========
    // bus level
    logic              drive;
    logic [DATA_W-1:0] wrData;
    logic [DATA_W-1:0] lastBus;
    // no pull on the bus: a floating bus toggles instead of holding stale data
    assign dataIn = !dataOeN ? dataOut : (drive ? wrData : ~lastBus);
    always @(posedge ref_clk) lastBus <= dataIn;
    initial begin
        {shiftClk, serialIn, drive, lastBus, wrData, addrBus} = '0;
        {csN, dataStrobeN, rdWrSel, readStrobeN, writeStrobeN} = 5'h1f;
    end
    // ==========
    // serial frame; shift clock stands still outside frames
    task automatic ser(input logic rw, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        logic [15:0] frame;
        frame = {rw, a, d};
        q = '0;
        @(posedge ref_clk);
        csN <= 1'b0;
        #17;
        for (int i = 15; i >= 0; i--) begin
            serialIn = frame[i];
            #40;
            if (serialOutEdgeSel && i < 8) q[i] = serialOut;
            shiftClk = 1'b1;
            #40;
            if (!serialOutEdgeSel && i > 0 && i < 9) q[i-1] = serialOut;
            shiftClk = 1'b0;
        end
        @(posedge ref_clk);
        csN <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask : ser
    // ==========
    // parallel access, strobe low and high six cycles each
    task automatic par(input logic split, input logic sel, input logic rw,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] q);
        @(posedge ref_clk);
        csN     <= !sel;
        rdWrSel <= rw;
        addrBus <= a;
        wrData  <= d;
        drive   <= !rw;
        @(posedge ref_clk);
        if (!split) dataStrobeN <= 1'b0;
        else if (rw) readStrobeN <= 1'b0;
        else writeStrobeN <= 1'b0;
        repeat (6) @(posedge ref_clk);
        q = dataIn;
        {dataStrobeN, readStrobeN, writeStrobeN} <= 3'h7;
        repeat (6) @(posedge ref_clk);
        csN   <= 1'b1;
        drive <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : par
endmodule : hci_micro_model
`default_nettype wire

// ---- sim/tb_host_control_interface.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_host_control_interface;
    import hci_pkg::*;
    logic                ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [APB_AW-1:0]   paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic                shiftClk, csN, serialIn, serialOutEdgeSel, serialOut, er;
    logic [ADDR_W-1:0]   addrBus;
    logic [DATA_W-1:0]   dataIn, dataOut, q;
    logic                dataOeN, dataStrobeN, rdWrSel, readStrobeN, writeStrobeN;
    logic [LINE_W-1:0]   ch1LineMode, commonLineMode;
    logic [LOOP_W-1:0]   ch2LoopMode;
    hci_hw_pins_s        hwPins;
    hci_host_wr_s        hostWr;
    int                  n_mismatch, checked;
    hci_host_control_interface dut (.ref_clk, .rst_n, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .shiftClk, .csN, .serialIn, .serialOutEdgeSel,
        .serialOut, .addrBus, .dataIn, .dataOut, .dataOeN, .dataStrobeN, .rdWrSel,
        .readStrobeN, .writeStrobeN, .hwPins, .hostWr, .ch1LineMode, .commonLineMode,
        .ch2LoopMode);
    hci_micro_model mcu (.ref_clk, .serialOutEdgeSel, .serialOut, .dataOut, .dataOeN,
        .shiftClk, .csN, .serialIn, .addrBus, .dataIn, .dataStrobeN, .rdWrSel,
        .readStrobeN, .writeStrobeN);
    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;
    // ==========
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic complete_run();
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    // watchdog: the sequence needs well under 100 us
    initial begin
        #400000;
        n_mismatch++;
        complete_run();
    end
    // ==========
    // sequence
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, serialOutEdgeSel, hwPins} = '0;
        n_mismatch = 0;
        checked = 0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        apb(1'b0, OFS_CTRL, '0);
        chk(rd, 32'(CTRL_RESET));
        apb(1'b0, 12'h010, '0);
        chk({rd[30:0], er}, 32'h0000_0001);
        apb(1'b1, OFS_RDDATA, 32'h0000_00a5);
        mcu.ser(1'b0, 7'h12, 8'h3c, q);
        apb(1'b0, OFS_LASTWR, '0);
        chk(rd, 32'h0001_123c);
        mcu.ser(1'b1, 7'h12, 8'h00, q);
        chk(32'(q), 32'h0000_00a5);
        serialOutEdgeSel <= 1'b1;
        mcu.ser(1'b1, 7'h12, 8'h00, q);
        chk(32'(q), 32'h0000_00a5);
        apb(1'b1, OFS_CTRL, 32'(MODE_STROBE));
        mcu.par(1'b0, 1'b1, 1'b0, 7'h21, 8'h5a, q);
        apb(1'b0, OFS_LASTWR, '0);
        chk(rd, 32'h0002_215a);
        mcu.par(1'b0, 1'b1, 1'b1, 7'h21, 8'h00, q);
        chk(32'(q), 32'h0000_00a5);
        apb(1'b1, OFS_CTRL, 32'(MODE_SPLIT));
        mcu.par(1'b1, 1'b1, 1'b0, 7'h33, 8'hc3, q);
        apb(1'b0, OFS_LASTWR, '0);
        chk(rd, 32'h0003_33c3);
        mcu.par(1'b1, 1'b1, 1'b1, 7'h33, 8'h00, q);
        chk(32'(q), 32'h0000_00a5);
        mcu.par(1'b1, 1'b0, 1'b0, 7'h44, 8'h11, q);
        apb(1'b0, OFS_LASTWR, '0);
        chk(rd, 32'h0003_33c3);
        // software asks for inband loop while the pins are in charge
        apb(1'b1, OFS_CTRL, 32'h0000_0024);
        for (int i = 0; i < 4; i++) begin
            hwPins <= {i[1:0], 4'(i * 5)};
            repeat (6) @(posedge ref_clk);
            chk(32'(ch2LoopMode), 32'(i));
            chk(32'(ch1LineMode), 32'(i * 5));
            chk(32'(commonLineMode), 32'(i * 5));
        end
        apb(1'b1, OFS_CTRL, 32'h0000_0020);
        repeat (4) @(posedge ref_clk);
        chk(32'(ch2LoopMode), 32'(LOOP_INBAND));
        complete_run();
    end
endmodule : tb_host_control_interface
`default_nettype wire
